/* logic/psc_consts.vh */
// constants for the protected system configuration register group
// assumes byte-wide registers reached by full 32-bit store addresses
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH

// register addresses
`define PSC_ADDR_WAIT     32'hfffff06e
`define PSC_ADDR_PROTECT_COMMAND_REG    32'hfffff1fc
`define PSC_ADDR_SYSST    32'hfffff802
`define PSC_ADDR_DBG      32'hfffff9fc
`define PSC_ADDR_OSC      32'hfffff80c
`define PSC_ADDR_WDT      32'hfffff6d0
`define PSC_ADDR_DMA0     32'hfffff0e0
`define PSC_ADDR_PSC      32'hfffff1fe
`define PSC_ADDR_CKC      32'hfffff822
`define PSC_ADDR_PCC      32'hfffff828
`define PSC_ADDR_CLM      32'hfffff824
`define PSC_ADDR_RESET_SOURCE_FLAGS     32'hfffff888
`define PSC_ADDR_LOW_VOLTAGE_DETECT_REG     32'hfffff890
`define PSC_ADDR_RAM_DATA_STATUS     32'hfffff892

// protected register indexes
`define PSC_IDX_PSC       3'd0
`define PSC_IDX_CKC       3'd1
`define PSC_IDX_PCC       3'd2
`define PSC_IDX_CLM       3'd3
`define PSC_IDX_RESET_SOURCE_FLAGS      3'd4
`define PSC_IDX_LOW_VOLTAGE_DETECT_REG      3'd5
`define PSC_IDX_RAM_DATA_STATUS      3'd6
`define PSC_IDX_DBG       3'd7
`define PSC_NUM_PROT      8
`define PSC_NUM_DMA       4

// reset values
`define PSC_RST_WAIT      8'h77
`define PSC_RST_DBG       8'h01
`define PSC_RST_OSC       8'h00
`define PSC_RST_WDT       8'h67
`define PSC_RST_PCC       8'h03
`define PSC_RST_CKC       8'h0a
`define PSC_RST_ZERO      8'h00

// field positions
`define PSC_PCC_SUBFB     7
`define PSC_PCC_MCK       6
`define PSC_PCC_MAINFB    5
`define PSC_PCC_CLS       4
`define PSC_PSC_STP       1
`define PSC_SYS_PRERR     0
`define PSC_WAIT_LSB      0
`define PSC_WAIT_W        3

// timing: base access length in clocks, minus the completing cycle
`define PSC_BASE_CLKS     3
`define PSC_BASE_CNT      4'd2

// bit operation codes
`define PSC_BOP_SET       2'd0
`define PSC_BOP_CLR       2'd1
`define PSC_BOP_NOT       2'd2

`endif

/* logic/psc_regs.v */
// protected system configuration register group with store unlock logic
// assumes the cpu holds a request until ack and issues one at a time;
// both resets are synchronous to sys_clk_in
`timescale 1ns/1ps
`include "psc_consts.vh"

// Notes on behaviour
// - register access takes three clocks plus programmed wait cycles
// - wait control resets to 0x77, byte access only; others except watchdog mode allow bit access
// - eight registers are protected, debug mode among them
// - protected store without unlock is dropped and flagged in system status
// - dma channel control registers reset to zero, channels off
// - debug register picks debug mode, debug pin use and pull-down
// - debug register written only with debug reset pin low and unlocked
// - debug register loads 0x01 on pin reset, kept on internal resets
// - writing zero to debug register gives normal mode, pins released
// - oscillator register resets to zero; stop bit halts the oscillator
// - watchdog runs from reset, mode register resets to 0x67
// - writing zero to watchdog mode stops the watchdog
// - clock control register at 0xfffff828, reset 0x03, documented fields
// - subclock feedback resistor used when bit is zero
// - main clock feedback resistor used when bit is zero
// - divider codes zero to five divide by 1 to 32; 011x refused
// - watchdog mode register accepts byte access only
// - clock status bit is read-only
module psc_regs (
  input  wire        sys_clk_in,
  input  wire        resetn_in,
  input  wire        int_reset_in,
  input  wire        req_in,
  input  wire        write_in,
  input  wire        bit_op_in,
  input  wire [1:0]  bit_code_in,
  input  wire [2:0]  bit_idx_in,
  input  wire [31:0] addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        debug_reset_pin_in,
  input  wire        clock_source_status_in,
  output reg         ack_out,
  output reg  [7:0]  rdata_out,
  output wire        debug_mode_out,
  output wire        debug_pins_out,
  output wire        debug_pulldown_out,
  output wire        osc_stop_out,
  output wire        wdt_run_out,
  output wire [7:0]  wdt_mode_out,
  output wire        stop_mode_out,
  output wire        sub_feedback_off_out,
  output wire        main_osc_stop_out,
  output wire        main_feedback_off_out,
  output wire [3:0]  cpu_div_sel_out,
  output wire [`PSC_NUM_DMA-1:0] dma_enable_out
);

  // protected register index decode, used by read and write paths
  function [3:0] prot_index;
    input [31:0] a;
    begin
      case (a)
        `PSC_ADDR_PSC:  prot_index = {1'b1, `PSC_IDX_PSC};
        `PSC_ADDR_CKC:  prot_index = {1'b1, `PSC_IDX_CKC};
        `PSC_ADDR_PCC:  prot_index = {1'b1, `PSC_IDX_PCC};
        `PSC_ADDR_CLM:  prot_index = {1'b1, `PSC_IDX_CLM};
        `PSC_ADDR_RESET_SOURCE_FLAGS: prot_index = {1'b1, `PSC_IDX_RESET_SOURCE_FLAGS};
        `PSC_ADDR_LOW_VOLTAGE_DETECT_REG: prot_index = {1'b1, `PSC_IDX_LOW_VOLTAGE_DETECT_REG};
        `PSC_ADDR_RAM_DATA_STATUS: prot_index = {1'b1, `PSC_IDX_RAM_DATA_STATUS};
        `PSC_ADDR_DBG:  prot_index = {1'b1, `PSC_IDX_DBG};
        default:        prot_index = 4'h0;
      endcase
    end
  endfunction

  // dma control decode: valid flag and channel number
  function [2:0] dma_index;
    input [31:0] a;
    begin
      if (a[31:4] == `PSC_ADDR_DMA0 >> 4 && a[1:0] == 2'b00) begin
        dma_index = {1'b1, a[3:2]};
      end else begin
        dma_index = 3'h0;
      end
    end
  endfunction

  // read-modify-write for single-bit instructions
  function [7:0] bit_apply;
    input [7:0] v;
    input [2:0] idx;
    input [1:0] code;
    begin
      bit_apply = v;
      case (code)
        `PSC_BOP_SET: bit_apply[idx] = 1'b1;
        `PSC_BOP_CLR: bit_apply[idx] = 1'b0;
        `PSC_BOP_NOT: bit_apply[idx] = ~v[idx];
        default:      bit_apply = v;
      endcase
    end
  endfunction

  // register storage
  reg [7:0] wait_ctrl;
  reg [7:0] sys_status;
  reg [7:0] osc_mode;
  reg [7:0] wdt_mode;
  reg [7:0] prot_mem [0:`PSC_NUM_PROT-1];
  reg [7:0] dma_ctrl [0:`PSC_NUM_DMA-1];
  reg       armed;

  // access sequencer
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  reg        state;
  reg [3:0]  cnt;
  reg        op_write;
  reg        op_bit;
  reg [1:0]  op_code;
  reg [2:0]  op_idx;
  reg [31:0] op_addr;
  reg [7:0]  op_data;

  wire       done = (state == ST_BUSY) && (cnt == 4'd0);
  wire [3:0] pidx = prot_index(op_addr);
  wire [2:0] didx = dma_index(op_addr);
  wire [3:0] wait_cnt = {1'b0, wait_ctrl[`PSC_WAIT_LSB +: `PSC_WAIT_W]};

  // current value of the addressed register, also the read data
  reg [7:0] cur;
  always @* begin
    cur = 8'h00;
    if (pidx[3]) begin
      cur = prot_mem[pidx[2:0]];
      if (pidx[2:0] == `PSC_IDX_PCC) begin
        cur[`PSC_PCC_CLS] = clock_source_status_in;
      end
    end else if (didx[2]) begin
      cur = dma_ctrl[didx[1:0]];
    end else begin
      case (op_addr)
        `PSC_ADDR_WAIT:  cur = wait_ctrl;
        `PSC_ADDR_SYSST: cur = sys_status;
        `PSC_ADDR_OSC:   cur = osc_mode;
        `PSC_ADDR_WDT:   cur = wdt_mode;
        default:         cur = 8'h00;
      endcase
    end
  end

  // value a store would leave behind
  wire [7:0] wval = op_bit ? bit_apply(cur, op_idx, op_code) : op_data;
  wire       st_done = done && op_write;
  // byte-only registers ignore bit instructions
  wire       byte_ok = !op_bit;
  wire       prot_st = st_done && pidx[3];
  wire       prot_ok = prot_st && armed;
  wire       dbg_ok  = prot_ok && (pidx[2:0] == `PSC_IDX_DBG) && !debug_reset_pin_in;

  // sequencer: take at idle, count base plus wait, then answer;
  // the cpu holds req through the edge that sees ack, so none is taken then
  always @(posedge sys_clk_in) begin
    if (!resetn_in || int_reset_in) begin
      state    <= ST_IDLE;
      cnt      <= 4'd0;
      op_write <= 1'b0;
      op_bit   <= 1'b0;
      op_code  <= 2'd0;
      op_idx   <= 3'd0;
      op_addr  <= 32'h00000000;
      op_data  <= 8'h00;
      ack_out  <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      ack_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_in && !ack_out) begin
            state    <= ST_BUSY;
            cnt      <= `PSC_BASE_CNT + wait_cnt;
            op_write <= write_in;
            op_bit   <= bit_op_in;
            op_code  <= bit_code_in;
            op_idx   <= bit_idx_in;
            op_addr  <= addr_in;
            op_data  <= wdata_in;
          end
        end
        ST_BUSY: begin
          if (cnt == 4'd0) begin
            state     <= ST_IDLE;
            ack_out   <= 1'b1;
            rdata_out <= cur;
          end else begin
            cnt <= cnt - 4'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // unlock: armed by a store to the command register, any other op disarms
  always @(posedge sys_clk_in) begin
    if (!resetn_in || int_reset_in) begin
      armed <= 1'b0;
    end else if (done) begin
      armed <= op_write && (op_addr == `PSC_ADDR_PROTECT_COMMAND_REG);
    end
  end

  // illegal protected store flag; a new error wins over a clear
  always @(posedge sys_clk_in) begin
    if (!resetn_in || int_reset_in) begin
      sys_status <= `PSC_RST_ZERO;
    end else if (prot_st && !armed) begin
      sys_status[`PSC_SYS_PRERR] <= 1'b1;
    end else if (st_done && op_addr == `PSC_ADDR_SYSST) begin
      sys_status[`PSC_SYS_PRERR] <= wval[`PSC_SYS_PRERR];
    end
  end

  // plain registers
  always @(posedge sys_clk_in) begin
    if (!resetn_in || int_reset_in) begin
      wait_ctrl <= `PSC_RST_WAIT;
      osc_mode  <= `PSC_RST_OSC;
      wdt_mode  <= `PSC_RST_WDT;
    end else if (st_done) begin
      if (op_addr == `PSC_ADDR_WAIT && byte_ok) begin
        wait_ctrl <= wval;
      end
      if (op_addr == `PSC_ADDR_OSC) begin
        osc_mode <= wval;
      end
      if (op_addr == `PSC_ADDR_WDT && byte_ok) begin
        wdt_mode <= wval;
      end
    end
  end

  // dma channel controls, all off from reset
  genvar g;
  generate
    for (g = 0; g < `PSC_NUM_DMA; g = g + 1) begin : g_dma
      always @(posedge sys_clk_in) begin
        if (!resetn_in || int_reset_in) begin
          dma_ctrl[g] <= `PSC_RST_ZERO;
        end else if (st_done && didx[2] && didx[1:0] == g) begin
          dma_ctrl[g] <= wval;
        end
      end
      assign dma_enable_out[g] = dma_ctrl[g][0];
    end
  endgenerate

  // protected registers; debug mode and clock control have their own branches
  generate
    for (g = 0; g < `PSC_NUM_PROT; g = g + 1) begin : g_prot
      if (g == `PSC_IDX_DBG) begin : g_dbg
        // debug mode survives internal resets, loads only on pin reset
        always @(posedge sys_clk_in) begin
          if (!resetn_in) begin
            prot_mem[g] <= `PSC_RST_DBG;
          end else if (dbg_ok && !int_reset_in) begin           // internal reset aborts the store
            prot_mem[g] <= wval;
          end
        end
      end else if (g == `PSC_IDX_PCC) begin : g_pcc
        // refused divider codes keep the old divider; status bit not stored
        always @(posedge sys_clk_in) begin
          if (!resetn_in || int_reset_in) begin
            prot_mem[g] <= `PSC_RST_PCC;
          end else if (prot_ok && pidx[2:0] == g) begin
            prot_mem[g][7:5] <= wval[7:5];
            if (wval[3:0] <= 4'h5) begin
              prot_mem[g][3:0] <= wval[3:0];
            end
          end
        end
      end else begin : g_other
        always @(posedge sys_clk_in) begin
          if (!resetn_in || int_reset_in) begin
            prot_mem[g] <= (g == `PSC_IDX_CKC) ? `PSC_RST_CKC : `PSC_RST_ZERO;
          end else if (prot_ok && pidx[2:0] == g) begin
            prot_mem[g] <= wval;
          end
        end
      end
    end
  endgenerate

  // debug mode: bit 0 set keeps debug mode, debug pins and the pull-down
  assign debug_mode_out     = prot_mem[`PSC_IDX_DBG][0];
  assign debug_pins_out     = prot_mem[`PSC_IDX_DBG][0];
  assign debug_pulldown_out = prot_mem[`PSC_IDX_DBG][0];

  // oscillator and watchdog controls
  assign osc_stop_out = osc_mode[0];
  assign wdt_run_out  = (wdt_mode != 8'h00);
  assign wdt_mode_out = wdt_mode;

  // stop request; cpu pads with no-ops after setting it
  assign stop_mode_out = prot_mem[`PSC_IDX_PSC][`PSC_PSC_STP];

  // clock control fields; a one disconnects a feedback resistor
  assign sub_feedback_off_out  = prot_mem[`PSC_IDX_PCC][`PSC_PCC_SUBFB];
  assign main_osc_stop_out     = prot_mem[`PSC_IDX_PCC][`PSC_PCC_MCK];
  assign main_feedback_off_out = prot_mem[`PSC_IDX_PCC][`PSC_PCC_MAINFB];
  assign cpu_div_sel_out       = prot_mem[`PSC_IDX_PCC][3:0];

endmodule // psc_regs

/* bench/psc_regs_asserts.sv */
// port assertions for the protected configuration register group
// assumes the cpu raises req_in only while the block is idle
`timescale 1ns/1ps
module psc_regs_asserts (
  input wire       sys_clk_in,
  input wire       resetn_in,
  input wire       int_reset_in,
  input wire       req_in,
  input wire       ack_out,
  input wire       debug_mode_out,
  input wire       debug_pins_out,
  input wire       debug_pulldown_out,
  input wire       wdt_run_out,
  input wire [7:0] wdt_mode_out,
  input wire [3:0] cpu_div_sel_out,
  input wire [3:0] dma_enable_out
);
  default clocking @(posedge sys_clk_in); endclocking
  // no access completes before its third clock
  sequence s_busy;
    !ack_out [*3];
  endsequence
  property p_lat; disable iff (!resetn_in || int_reset_in) $rose(req_in) |-> s_busy ##[1:9] ack_out; endproperty
  a_lat: assert property (p_lat) else $error("access latency out of range");
  property p_pulse; disable iff (!resetn_in) ack_out |=> !ack_out; endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  // reset values are checked with reset as the cause, so no disable
  property p_dbg_rst; !resetn_in |=> debug_mode_out; endproperty
  a_dbg_rst: assert property (p_dbg_rst) else $error("debug bit not set by pin reset");
  property p_dbg_keep; disable iff (!resetn_in) int_reset_in |=> debug_mode_out == $past(debug_mode_out); endproperty
  a_dbg_keep: assert property (p_dbg_keep) else $error("debug bit lost on internal reset");
  property p_wdt_rst; (!resetn_in || int_reset_in) |=> wdt_mode_out == 8'h67 && wdt_run_out; endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog mode reset value wrong");
  property p_div_rst; !resetn_in |=> cpu_div_sel_out == 4'h3 && dma_enable_out == 4'h0; endproperty
  a_div_rst: assert property (p_div_rst) else $error("divider or dma reset value wrong");
  property p_wdt_run; disable iff (!resetn_in) wdt_run_out == (wdt_mode_out != 8'h00); endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog run flag disagrees with mode");
  property p_div_ok; disable iff (!resetn_in) cpu_div_sel_out <= 4'h5; endproperty
  a_div_ok: assert property (p_div_ok) else $error("prohibited divider code taken");
  property p_dbg_fan; disable iff (!resetn_in) debug_pins_out == debug_mode_out && debug_pulldown_out == debug_mode_out; endproperty
  a_dbg_fan: assert property (p_dbg_fan) else $error("debug outputs disagree");
endmodule // psc_regs_asserts

bind psc_regs psc_regs_asserts chk (.*);

/* bench/psc_cpu_model.sv */
// cpu model issuing one register access at a time on the store path
// assumes the block acks each access with a one-cycle pulse
`timescale 1ns/1ps
`include "psc_consts.vh"
module psc_cpu_model (
  input  wire        clk_in,
  input  wire        ack_in,
  input  wire [7:0]  rdata_in,
  output reg         req_out,
  output reg         write_out,
  output reg         bit_op_out,
  output reg  [1:0]  bit_code_out,
  output reg  [2:0]  bit_idx_out,
  output reg  [31:0] addr_out,
  output reg  [7:0]  wdata_out
);
  reg     [7:0] rdv;
  integer       n;
  initial {req_out, write_out, bit_op_out, bit_code_out, bit_idx_out, addr_out, wdata_out} = 0;
  // hold all qualifiers through the edge that samples ack high, then release;
  // for bit instructions the low data bits give the bit number
  task access(input w, input b, input [1:0] c, input [31:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      #1;
      {req_out, write_out, bit_op_out, bit_code_out, bit_idx_out} = {1'b1, w, b, c, d[2:0]};
      {addr_out, wdata_out} = {a, d};
      n = 0;
      @(posedge clk_in);
      while (!ack_in && n < 40) begin
        @(posedge clk_in);
        n = n + 1;
      end
      rdv = rdata_in; // read data stands with ack at this edge
      #1;
      req_out = 1'b0;
      {addr_out, wdata_out} = ~{a, d}; // released lines never keep the last value
    end
  endtask
  // dma off, unlock store, then the guarded store itself
  task prot(input [31:0] a, input [7:0] d);
    integer k;
    begin
      for (k = 0; k < `PSC_NUM_DMA; k = k + 1) begin
        access(1'b1, 1'b0, 2'd0, `PSC_ADDR_DMA0 + 4 * k, 8'h00);
      end
      access(1'b1, 1'b0, 2'd0, `PSC_ADDR_PROTECT_COMMAND_REG, d);
      access(1'b1, 1'b0, 2'd0, a, d);
      if (a == `PSC_ADDR_PSC && d[1]) begin
        repeat (5) @(posedge clk_in);
      end
    end
  endtask
endmodule // psc_cpu_model

/* bench/protected_system_config_regs_tb.sv */
// self-checking bench for the protected configuration register group
// assumes psc_cpu_model drives the access port; checker bound to psc_regs
`timescale 1ns/1ps
`include "psc_consts.vh"
module protected_system_config_regs_tb;
  reg         sys_clk_in = 1'b0;
  reg         resetn_in = 1'b0;
  reg         int_reset_in = 1'b0;
  reg         dbg_pin = 1'b0;
  reg         clock_source_status = 1'b0;
  reg  [15:0] rs = 16'h3740;
  reg  [3:0]  div;
  integer     mismatches = 0;
  integer     checked = 0;
  integer     k;
  wire        req, wen, bop, ack, dmode, dpins, dpull, osc, wrun, stop_mode_bit, sfb, mstop, mfb;
  wire [1:0]  code;
  wire [2:0]  idx;
  wire [31:0] addr;
  wire [7:0]  wd, rdat, wmode;
  wire [3:0]  dsel, dma;
  always #4 sys_clk_in = ~sys_clk_in;
  psc_cpu_model cpu (.clk_in(sys_clk_in), .ack_in(ack), .rdata_in(rdat), .req_out(req),
    .write_out(wen), .bit_op_out(bop), .bit_code_out(code), .bit_idx_out(idx),
    .addr_out(addr), .wdata_out(wd));
  psc_regs uut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .int_reset_in(int_reset_in),
    .req_in(req), .write_in(wen), .bit_op_in(bop), .bit_code_in(code), .bit_idx_in(idx),
    .addr_in(addr), .wdata_in(wd), .debug_reset_pin_in(dbg_pin),
    .clock_source_status_in(clock_source_status), .ack_out(ack), .rdata_out(rdat), .debug_mode_out(dmode),
    .debug_pins_out(dpins), .debug_pulldown_out(dpull), .osc_stop_out(osc),
    .wdt_run_out(wrun), .wdt_mode_out(wmode), .stop_mode_out(stop_mode_bit),
    .sub_feedback_off_out(sfb), .main_osc_stop_out(mstop), .main_feedback_off_out(mfb),
    .cpu_div_sel_out(dsel), .dma_enable_out(dma));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // prohibited codes leave the divider alone
  function [3:0] exp_div(input [3:0] old, input [3:0] c);
    exp_div = (c <= 4'h5) ? c : old;
  endfunction
  task wrap_up;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one access or guarded store, with the hang guard
  task go(input pr, input w, input b, input [1:0] c, input [31:0] a, input [7:0] d);
    begin
      if (pr) cpu.prot(a, d);
      else cpu.access(w, b, c, a, d);
      if (cpu.n >= 40) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t access never acknowledged", $time);
        wrap_up;
      end
    end
  endtask
  task rd(input [31:0] a, input [7:0] e);
    begin
      go(0, 0, 0, 0, a, 8'h00);
      chk(cpu.rdv, e);
    end
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    mismatches = mismatches + 1;
    $display("[ERR] %0t run limit reached", $time);
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    #1;
    resetn_in = 1'b1;
    rd(`PSC_ADDR_WAIT, 8'h77);
    chk(cpu.n[7:0], 8'd11);
    rd(`PSC_ADDR_DBG, 8'h01);
    rd(`PSC_ADDR_OSC, 8'h00);
    rd(`PSC_ADDR_WDT, 8'h67);
    rd(`PSC_ADDR_PCC, 8'h03);
    for (k = 0; k < 4; k = k + 1) rd(`PSC_ADDR_DMA0 + 4 * k, 8'h00);
    rd(32'hfffff000, 8'h00);
    $display("test reset values done");
    for (k = 0; k < 4; k = k + 1) begin
      rs = lfsr(rs);
      go(0, 1, 0, 0, `PSC_ADDR_WAIT, rs[7:0]);
      go(0, 0, 0, 0, `PSC_ADDR_WAIT, 8'h00);
      chk(cpu.rdv, rs[7:0]);
      chk(cpu.n[7:0], 8'd4 + {5'h00, rs[2:0]});
    end
    go(0, 1, 0, 0, `PSC_ADDR_WAIT, 8'h00);
    go(0, 1, 1, `PSC_BOP_NOT, `PSC_ADDR_WAIT, 8'h00);
    rd(`PSC_ADDR_WAIT, 8'h00);
    chk(cpu.n[7:0], 8'd4);
    $display("test wait timing done");
    go(0, 1, 0, 0, `PSC_ADDR_PCC, 8'h00);
    rd(`PSC_ADDR_SYSST, 8'h01);
    go(0, 1, 0, 0, `PSC_ADDR_SYSST, 8'h00);
    go(0, 1, 0, 0, `PSC_ADDR_PROTECT_COMMAND_REG, 8'h00);
    rd(`PSC_ADDR_SYSST, 8'h00);
    go(0, 1, 0, 0, `PSC_ADDR_PCC, 8'h00);
    rd(`PSC_ADDR_PCC, 8'h03);
    go(0, 1, 0, 0, `PSC_ADDR_SYSST, 8'h00);
    div = 4'h3;
    // every divider code, random upper bits and status pin level
    for (k = 0; k < 16; k = k + 1) begin
      rs = lfsr(rs);
      clock_source_status = rs[8];
      div = exp_div(div, k[3:0]);
      go(1, 1, 0, 0, `PSC_ADDR_PCC, {rs[7:5], 1'b1, k[3:0]});
      rd(`PSC_ADDR_PCC, {rs[7:5], clock_source_status, div});
      chk({sfb, mstop, mfb, 1'b0, dsel}, {rs[7:5], 1'b0, div});
    end
    dbg_pin = 1'b1;
    go(1, 1, 0, 0, `PSC_ADDR_DBG, 8'h00);
    rd(`PSC_ADDR_DBG, 8'h01);
    rd(`PSC_ADDR_SYSST, 8'h00);
    dbg_pin = 1'b0;
    go(1, 1, 0, 0, `PSC_ADDR_DBG, 8'h00);
    rd(`PSC_ADDR_DBG, 8'h00);
    chk({5'h00, dmode, dpins, dpull}, 8'h00);
    go(0, 1, 0, 0, `PSC_ADDR_DMA0 + 4, 8'h01);
    rd(`PSC_ADDR_DMA0 + 4, 8'h01);
    chk({4'h0, dma}, 8'h02);
    go(1, 1, 0, 0, `PSC_ADDR_PSC, 8'h02);
    chk({3'h0, stop_mode_bit, dma}, 8'h10);
    $display("test protection done");
    go(0, 1, 1, `PSC_BOP_SET, `PSC_ADDR_OSC, 8'h05);
    rd(`PSC_ADDR_OSC, 8'h20);
    go(0, 1, 1, `PSC_BOP_NOT, `PSC_ADDR_OSC, 8'h00);
    rd(`PSC_ADDR_OSC, 8'h21);
    go(0, 1, 1, `PSC_BOP_CLR, `PSC_ADDR_OSC, 8'h05);
    rd(`PSC_ADDR_OSC, 8'h01);
    go(0, 1, 1, `PSC_BOP_NOT, `PSC_ADDR_WDT, 8'h00);
    rd(`PSC_ADDR_WDT, 8'h67);
    go(0, 1, 0, 0, `PSC_ADDR_WDT, 8'h00);
    rd(`PSC_ADDR_WDT, 8'h00);
    chk({osc, wrun, 6'h00}, 8'h80);
    chk(wmode, 8'h00);
    // internal reset keeps the debug bit, pin reset reloads it
    int_reset_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    int_reset_in = 1'b0;
    rd(`PSC_ADDR_DBG, 8'h00);
    rd(`PSC_ADDR_WDT, 8'h67);
    resetn_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
    resetn_in = 1'b1;
    rd(`PSC_ADDR_DBG, 8'h01);
    $display("test resets done");
    wrap_up;
  end
endmodule // protected_system_config_regs_tb
